// File: rcs_run_sequencer.sv
// Run-command sequencer: push-button latching, run-enable gating
// with stop modes, and acceleration/deceleration dwell.
// Assumes synchronous terminal inputs and an APB master on clk.
//
// Operation
// - Latch momentary buttons in three-wire terminal mode
// - Forward and reverse together stop the drive
// - Run-enable terminal gates acceptance of run commands
// - Selection zero ignores run-enable gating
// - Selection one follows the run-enable terminal
// - Coast mode blocks output on enable loss
// - Quick stop ramps down, needs fresh command
// - Enable loss in quick-stop mode decelerates with quick-stop time
// - Dwell only in volts-per-hertz control mode
// - Accelerate to dwell frequency, hold, continue
// - Decelerate to dwell frequency, hold, stop
// - Zero time or frequency skips dwell
// - Re-acceleration never dwells
// - Deceleration dwell only on stop command
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module rcs_run_sequencer
  import rcs_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Terminals
  input  wire logic        fwdIn,
  input  wire logic        revIn,
  input  wire logic [7:0]  diIn,
  // Drive output
  output logic [15:0]      outFreq,
  output logic             outEnable,
  output logic             dirRev
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  rcs_ctrl_t   ctrl_ff;
  logic [31:0] funcLo_ff;
  logic [31:0] funcHi_ff;
  logic [15:0] fref_ff;
  logic [12:0] accT_ff;
  logic [12:0] decT_ff;
  logic [12:0] qstopT_ff;
  rcs_dwell_t  aDwell_ff;
  rcs_dwell_t  dDwell_ff;
  logic [15:0] maxF_ff;

  rcs_state_t  state_ff;
  logic [15:0] freq_ff;
  logic [23:0] acc_ff;
  logic [16:0] holdMs_ff;
  logic        latch_ff;
  logic        lockout_ff;
  logic        dwPend_ff;
  logic        tick;

  logic        wrEn;
  logic        mapped;
  logic [31:0] rdVal;

  assign wrEn = psel & penable & pready & pwrite;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      A_CTRL:   rdVal = {18'h0, ctrl_ff.stopMode, 3'h0, ctrl_ff.runEnSel,
                         1'b0, ctrl_ff.ctrlMode, 1'b0, ctrl_ff.cmdSource};
      A_FUNCLO: rdVal = funcLo_ff;
      A_FUNCHI: rdVal = funcHi_ff;
      A_FREF:   rdVal = {16'h0, fref_ff};
      A_ACCT:   rdVal = {19'h0, accT_ff};
      A_DECT:   rdVal = {19'h0, decT_ff};
      A_QSTOP:  rdVal = {19'h0, qstopT_ff};
      A_ADWELL: rdVal = {6'h0, aDwell_ff};
      A_DDWELL: rdVal = {6'h0, dDwell_ff};
      A_MAXF:   rdVal = {16'h0, maxF_ff};
      A_STATUS: rdVal = {freq_ff, 8'h0, dirRev, outEnable, lockout_ff,
                         latch_ff, 1'b0, state_ff};
      default: begin
        rdVal  = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB: one wait-free access phase, read data caught at setup
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rdVal : 32'h0;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff   <= '{stopMode: 2'h0, runEnSel: GATE_FOLLOWS,
                     ctrlMode: MODE_VF, cmdSource: SRC_TERM_FR};
      funcLo_ff <= 32'h0;
      funcHi_ff <= 32'h0;
      fref_ff   <= RST_FREF;
      accT_ff   <= RST_RAMPT;
      decT_ff   <= RST_RAMPT;
      qstopT_ff <= RST_QSTOP;
      aDwell_ff <= '{time_ds: RST_DWTIME, freq: RST_DWFREQ};
      dDwell_ff <= '{time_ds: RST_DWTIME, freq: RST_DWFREQ};
      maxF_ff   <= RST_MAXF;
    end else if (wrEn) begin
      case (paddr)
        A_CTRL: begin
          ctrl_ff.cmdSource <= pwdata[2:0];
          ctrl_ff.ctrlMode  <= pwdata[6:4];
          ctrl_ff.runEnSel  <= pwdata[8];
          ctrl_ff.stopMode  <= pwdata[13:12];
        end
        A_FUNCLO: funcLo_ff <= pwdata & 32'h3F3F3F3F;
        A_FUNCHI: funcHi_ff <= pwdata & 32'h3F3F3F3F;
        A_FREF:   fref_ff   <= pwdata[15:0];
        A_ACCT:   accT_ff   <= pwdata[12:0];
        A_DECT:   decT_ff   <= pwdata[12:0];
        A_QSTOP:  qstopT_ff <= pwdata[12:0];
        A_ADWELL: aDwell_ff <= pwdata[25:0];
        A_DDWELL: dDwell_ff <= pwdata[25:0];
        A_MAXF:   maxF_ff   <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Terminal function decode
  // ----------------------------------------------------------------
  logic [NUM_TERM-1:0] isRunEn;
  logic [NUM_TERM-1:0] is3Wire;
  logic [NUM_TERM-1:0] runEnLvl;
  logic [NUM_TERM-1:0] stopLvl;

  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    logic [5:0] fn;
    if (t < TERMS_PER_RG) begin : g_lo
      assign fn = funcLo_ff[t*8 +: 6];
    end else begin : g_hi
      assign fn = funcHi_ff[(t-TERMS_PER_RG)*8 +: 6];
    end
    assign isRunEn[t]  = (fn == FN_RUN_EN);
    assign is3Wire[t]  = (fn == FN_3WIRE);
    assign runEnLvl[t] = isRunEn[t] & diIn[t];
    assign stopLvl[t]  = is3Wire[t] & diIn[t];
  end

  logic threeWire;
  logic stopClosed;
  logic gateOk;
  logic bothCmd;
  logic runCmd;

  // Stop contact is normally closed; every assigned one must be made
  assign threeWire  = (ctrl_ff.cmdSource == SRC_TERM_FR) & (|is3Wire);
  assign stopClosed = ((stopLvl | ~is3Wire) == {NUM_TERM{1'b1}});
  // No terminal assigned means nothing to wait for
  assign gateOk = (ctrl_ff.runEnSel != GATE_FOLLOWS)
                | ~(|isRunEn) | (|runEnLvl);
  assign bothCmd = fwdIn & revIn;

  // ----------------------------------------------------------------
  // Push-button latch, sampled on ticks so a 1 ms press is seen
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_ff <= 1'b0;
      dirRev   <= 1'b0;
    end else if (!threeWire) begin
      latch_ff <= 1'b0;
      if (state_ff == ST_IDLE && (fwdIn ^ revIn))
        dirRev <= revIn;
    end else if (!stopClosed || bothCmd) begin
      latch_ff <= 1'b0;
    end else if (tick && (fwdIn || revIn)) begin
      latch_ff <= 1'b1;
      dirRev   <= revIn;
    end
  end

  // Level mode also refuses both directions at once
  assign runCmd = threeWire ? latch_ff : (fwdIn ^ revIn);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic        vfMode;
  logic        aDwOn;
  logic        dDwOn;
  logic [16:0] aHoldMs;
  logic [16:0] dHoldMs;
  logic        coast;

  assign vfMode  = (ctrl_ff.ctrlMode == MODE_VF);
  assign aDwOn   = vfMode & (aDwell_ff.time_ds != 10'h0)
                 & (aDwell_ff.freq != 16'h0);
  assign dDwOn   = vfMode & (dDwell_ff.time_ds != 10'h0)
                 & (dDwell_ff.freq != 16'h0);
  assign aHoldMs = 17'(aDwell_ff.time_ds * MS_PER_DSEC);
  assign dHoldMs = 17'(dDwell_ff.time_ds * MS_PER_DSEC);
  assign coast   = ~gateOk & (ctrl_ff.stopMode != STOP_QUICK)
                 & (state_ff != ST_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      holdMs_ff  <= 17'h0;
      lockout_ff <= 1'b0;
      dwPend_ff  <= 1'b0;
    end else begin
      if (!runCmd)
        lockout_ff <= 1'b0;
      if (tick)
        holdMs_ff <= holdMs_ff + 17'h1;
      if (!gateOk && state_ff != ST_IDLE && state_ff != ST_QSTOP) begin
        if (ctrl_ff.stopMode == STOP_QUICK)
          state_ff <= ST_QSTOP;
        else
          state_ff <= ST_IDLE;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            holdMs_ff <= 17'h0;
            if (runCmd && gateOk && !lockout_ff)
              state_ff <= aDwOn ? ST_ACCDW : ST_RUN;
          end
          ST_ACCDW: begin
            holdMs_ff <= 17'h0;
            if (!runCmd) begin
              dwPend_ff <= dDwOn & (freq_ff > dDwell_ff.freq);
              state_ff  <= ST_DECEL;
            end else if (freq_ff == aDwell_ff.freq) begin
              state_ff <= ST_AHOLD;
            end
          end
          ST_AHOLD: begin
            if (!runCmd) begin
              dwPend_ff <= dDwOn & (freq_ff > dDwell_ff.freq);
              state_ff  <= ST_DECEL;
            end else if (holdMs_ff >= aHoldMs) begin
              state_ff <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (!runCmd) begin
              dwPend_ff <= dDwOn & (freq_ff > dDwell_ff.freq);
              state_ff  <= ST_DECEL;
            end
          end
          ST_DECEL: begin
            holdMs_ff <= 17'h0;
            if (runCmd)
              state_ff <= ST_RUN;
            else if (dwPend_ff && freq_ff <= dDwell_ff.freq)
              state_ff <= ST_DHOLD;
            else if (freq_ff == 16'h0)
              state_ff <= ST_IDLE;
          end
          ST_DHOLD: begin
            if (runCmd) begin
              dwPend_ff <= 1'b0;
              state_ff  <= ST_RUN;
            end else if (holdMs_ff >= dHoldMs) begin
              dwPend_ff <= 1'b0;
              state_ff  <= ST_DECEL;
            end
          end
          ST_QSTOP: begin
            if (freq_ff == 16'h0) begin
              lockout_ff <= runCmd;
              state_ff   <= ST_IDLE;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Frequency ramp
  // ----------------------------------------------------------------
  logic [15:0] tgt;
  logic [12:0] rampT;
  logic [23:0] den;
  logic        hold;

  always_comb begin
    hold  = 1'b0;
    rampT = accT_ff;
    case (state_ff)
      ST_ACCDW: tgt = aDwell_ff.freq;
      ST_RUN:   tgt = fref_ff;
      ST_DECEL: tgt = (dwPend_ff && freq_ff > dDwell_ff.freq)
                      ? dDwell_ff.freq : 16'h0;
      ST_QSTOP: tgt = 16'h0;
      default: begin
        tgt  = freq_ff;
        hold = 1'b1;
      end
    endcase
    if (state_ff == ST_QSTOP)
      rampT = qstopT_ff;
    else if (tgt < freq_ff)
      rampT = decT_ff;
  end

  // Full-scale ramp spread over rampT; zero time jumps at once
  assign den = 24'(rampT * MS_PER_DSEC);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_ff <= 16'h0;
      acc_ff  <= 24'h0;
    end else if (coast || state_ff == ST_IDLE || hold) begin
      freq_ff <= hold ? freq_ff : 16'h0;
      acc_ff  <= 24'h0;
    end else if (tgt == freq_ff) begin
      acc_ff <= 24'h0;
    end else if (den == 24'h0) begin
      freq_ff <= tgt;
    end else if (acc_ff >= den) begin
      acc_ff  <= acc_ff - den;
      freq_ff <= (tgt > freq_ff) ? freq_ff + 16'h1 : freq_ff - 16'h1;
    end else if (tick) begin
      acc_ff <= acc_ff + {8'h0, maxF_ff};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outFreq   <= 16'h0;
      outEnable <= 1'b0;
    end else begin
      outFreq   <= coast ? 16'h0 : freq_ff;
      outEnable <= ~coast & (state_ff != ST_IDLE);
    end
  end

  rcs_ms_tick #(
    .TICK_CYC (TICK_CYC_P)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

endmodule : rcs_run_sequencer

// File: rcs_pkg.sv
// Constants, register map and carrier types of the run-command sequencer.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package rcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int MS_PER_DSEC   = 100;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_FUNCLO = 8'h04;
  localparam logic [7:0] A_FUNCHI = 8'h08;
  localparam logic [7:0] A_FREF   = 8'h0C;
  localparam logic [7:0] A_ACCT   = 8'h10;
  localparam logic [7:0] A_DECT   = 8'h14;
  localparam logic [7:0] A_QSTOP  = 8'h18;
  localparam logic [7:0] A_ADWELL = 8'h1C;
  localparam logic [7:0] A_DDWELL = 8'h20;
  localparam logic [7:0] A_MAXF   = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam int          NUM_TERM     = 8;
  localparam int          TERMS_PER_RG = 4;
  localparam logic [5:0]  FN_RUN_EN    = 6'h0D;
  localparam logic [5:0]  FN_3WIRE     = 6'h0E;
  localparam logic [2:0]  SRC_TERM_FR  = 3'h1;
  localparam logic [2:0]  MODE_VF      = 3'h0;
  localparam logic        GATE_FOLLOWS = 1'h1;
  localparam logic [1:0]  STOP_QUICK   = 2'h2;

  // ----------------------------------------------------------------
  // Reset values (freq 0.01 Hz, times 0.1 s)
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_FREF   = 16'h0000;
  localparam logic [12:0] RST_RAMPT  = 13'h0064;
  localparam logic [12:0] RST_QSTOP  = 13'h0032;
  localparam logic [15:0] RST_DWFREQ = 16'h01F4;
  localparam logic [9:0]  RST_DWTIME = 10'h000;
  localparam logic [15:0] RST_MAXF   = 16'h1770;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] stopMode;
    logic       runEnSel;
    logic [2:0] ctrlMode;
    logic [2:0] cmdSource;
  } rcs_ctrl_t;

  typedef struct packed {
    logic [9:0]  time_ds;
    logic [15:0] freq;
  } rcs_dwell_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACCDW, ST_AHOLD, ST_RUN, ST_DECEL, ST_DHOLD, ST_QSTOP
  } rcs_state_t;

endpackage : rcs_pkg

// File: rcs_ms_tick.sv
// Millisecond tick generator for the run-command sequencer.
// Assumes one free-running clock; tick is a one-cycle pulse.
`timescale 1ns/1ps
module rcs_ms_tick #(
  parameter int TICK_CYC = 100000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Tick
  output logic      tick
);

  logic [31:0] cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0;
      tick   <= 1'b0;
    end else if (cnt_ff == 32'(TICK_CYC - 1)) begin
      cnt_ff <= 32'h0;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick   <= 1'b0;
    end
  end

endmodule : rcs_ms_tick

// File: rcs_run_sequencer_props.sv
// Port checker for the run-command sequencer, bound at the foot.
// Assumes one clock domain with asynchronous active-high reset.
`timescale 1ns/1ps
module rcs_run_sequencer_props
  import rcs_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Terminals and drive
  input wire logic        fwdIn,
  input wire logic        revIn,
  input wire logic [15:0] outFreq,
  input wire logic        outEnable
);
  int bothCnt_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Latch clears the cycle after both are seen; allow one tick plus pipeline
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      bothCnt_ff <= 0;
    else if (!(fwdIn && revIn))
      bothCnt_ff <= 0;
    else if (bothCnt_ff < TICK_CYC_P + 4)
      bothCnt_ff <= bothCnt_ff + 1;
  end

  sequence s_setup;
    psel && !penable;
  endsequence

  AST_APB_READY: assert property (s_setup |=> pready && psel && penable)
    else $error("pready missing after setup");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_APB_ERR: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access phase");
  AST_APB_RDZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  AST_BOTH_STOP: assert property (
    bothCnt_ff >= TICK_CYC_P + 4 |-> outFreq <= $past(outFreq))
    else $error("frequency rose with both commands");
  AST_COAST_ZERO: assert property (!outEnable |-> outFreq == 16'h0000)
    else $error("frequency while output blocked");
  AST_RAMP_STEP: assert property (outFreq == 16'h0000 ||
    ({1'b0, outFreq} <= {1'b0, $past(outFreq)} + 17'h1 &&
     {1'b0, outFreq} + 17'h1 >= {1'b0, $past(outFreq)}))
    else $error("frequency jumped more than one step");
  AST_START_LOW: assert property ($rose(outEnable) |-> outFreq <= 16'h0001)
    else $error("start not from standstill");
endmodule : rcs_run_sequencer_props

bind rcs_run_sequencer rcs_run_sequencer_props #(.TICK_CYC_P(TICK_CYC_P)) u_props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .fwdIn(fwdIn), .revIn(revIn),
  .outFreq(outFreq), .outEnable(outEnable));

// File: rcs_pb_model.sv
// Push-button and switch contacts on the sequencer's terminals.
// Terminal 0 is run enable, terminal 1 the normally closed stop.
`timescale 1ns/1ps
module rcs_pb_model #(
  parameter int HOLD_CYC = 22
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Requests from the bench
  input  wire logic  fwdReq,
  input  wire logic  revReq,
  input  wire logic  enOn,
  input  wire logic  stopOpen,
  // Contacts
  output logic       fwdIn,
  output logic       revIn,
  output logic [7:0] diIn
);
  int   holdCnt_ff;
  logic fwdHold_ff;
  logic revHold_ff;

  // Press held past one tick, else the latch may miss it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holdCnt_ff <= 0;
      fwdHold_ff <= 1'b0;
      revHold_ff <= 1'b0;
    end else if (fwdReq || revReq) begin
      holdCnt_ff <= HOLD_CYC;
      fwdHold_ff <= fwdReq;
      revHold_ff <= revReq;
    end else if (holdCnt_ff != 0) begin
      holdCnt_ff <= holdCnt_ff - 1;
    end
  end

  assign fwdIn = fwdHold_ff && holdCnt_ff != 0;
  assign revIn = revHold_ff && holdCnt_ff != 0;
  assign diIn  = {6'h00, ~stopOpen, enOn};
endmodule : rcs_pb_model

// File: rcs_run_sequencer_tb.sv
// Self-checking bench for the run-command sequencer.
// Assumes the contact model on the terminals; the bench is APB master.
`timescale 1ns/1ps
module rcs_run_sequencer_tb import rcs_pkg::*;;
  localparam int TCK = 10;
  typedef struct packed {logic [2:0] sel; logic [31:0] exp;} rcs_note_t;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, errSeen;
  logic        fwdReq, revReq, enOn, stopOpen, fwdIn, revIn, outEnable, dirRev;
  logic [7:0]  paddr, diIn;
  logic [31:0] pwdata, prdata, rdSeen, obs;
  logic [15:0] outFreq, fref;
  rcs_note_t   noteQ[$];
  rcs_note_t   curNote;
  int          err_count, compares;
  string       nm[5] = '{"outFreq", "prdata", "pslverr", "outEnable", "dirRev"};
  logic [7:0]  rAdr[6] = '{A_CTRL, A_ACCT, A_QSTOP, A_ADWELL, A_MAXF, 8'h2C};
  logic [31:0] rExp[6] = '{32'h101, {19'h0, RST_RAMPT}, {19'h0, RST_QSTOP},
                           {16'h0, RST_DWFREQ}, {16'h0, RST_MAXF}, 32'h0};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  rcs_run_sequencer #(.TICK_CYC_P(TCK)) u_rcs_run_sequencer (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .fwdIn(fwdIn), .revIn(revIn),
    .diIn(diIn), .outFreq(outFreq), .outEnable(outEnable), .dirRev(dirRev));
  rcs_pb_model #(.HOLD_CYC(2 * TCK + 2)) u_rcs_pb_model (.clk(clk), .rst(rst),
    .fwdReq(fwdReq), .revReq(revReq), .enOn(enOn), .stopOpen(stopOpen),
    .fwdIn(fwdIn), .revIn(revIn), .diIn(diIn));

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("unexpected pready: expected 1 seen %b", pready);
      err_count++;
    end
    rdSeen  = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic note(input logic [2:0] s, input logic [31:0] e);
    noteQ.push_back('{sel: s, exp: e});
    repeat (2) @(negedge clk);
  endtask : note

  task automatic press(input logic f, input logic r);
    @(posedge clk);
    fwdReq <= f;
    revReq <= r;
    @(posedge clk);
    fwdReq <= 1'b0;
    revReq <= 1'b0;
  endtask : press

  task automatic waitFreq(input logic [15:0] f, input int lim);
    int n;
    n = 0;
    while (outFreq !== f && n < lim) begin
      @(negedge clk);
      n++;
    end
    note(3'h0, {16'h0, f});
  endtask : waitFreq

  // Opening the stop contact drops the latch
  task automatic stopNow;
    @(posedge clk);
    stopOpen <= 1'b1;
    repeat (2 * TCK + 2) @(posedge clk);
    stopOpen <= 1'b0;
    waitFreq(16'h0, 3000);
  endtask : stopNow

  task automatic summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  always @(negedge clk) begin
    if (noteQ.size() != 0) begin
      curNote = noteQ.pop_front();
      case (curNote.sel)
        3'h0: obs = {16'h0, outFreq};
        3'h1: obs = rdSeen;
        3'h2: obs = {31'h0, errSeen};
        3'h3: obs = {31'h0, outEnable};
        default: obs = {31'h0, dirRev};
      endcase
      compares++;
      if (obs !== curNote.exp) begin
        $display("unexpected %s: expected %h seen %h", nm[curNote.sel], curNote.exp, obs);
        err_count++;
      end
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    {rst, enOn} = 2'h3;
    {psel, penable, pwrite, fwdReq, revReq, stopOpen} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(32'h42CCAD56));
    fref = 16'h001E + 16'($urandom % 31);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rAdr[i], 32'h0);
      note(3'h1, rExp[i]);
      note(3'h2, {31'h0, i == 5});
    end
    apb(1'b1, A_FUNCLO, 32'h00000E0D);
    apb(1'b1, A_MAXF, 32'h64);
    apb(1'b1, A_ACCT, 32'h1);
    apb(1'b1, A_DECT, 32'h1);
    apb(1'b1, A_QSTOP, 32'h1);
    apb(1'b1, A_FREF, {16'h0, fref});
    apb(1'b1, A_CTRL, 32'h1101);
    press(1'b1, 1'b0);
    waitFreq(fref, 3000);
    note(3'h3, 32'h1);
    stopNow();
    press(1'b1, 1'b0);
    waitFreq(fref, 3000);
    press(1'b1, 1'b1);
    waitFreq(16'h0, 3000);
    press(1'b0, 1'b1);
    waitFreq(fref, 3000);
    note(3'h4, 32'h1);
    @(posedge clk);
    enOn <= 1'b0;
    repeat (5) @(negedge clk);
    note(3'h3, 32'h0);
    @(posedge clk);
    enOn <= 1'b1;
    waitFreq(fref, 3000);
    stopNow();
    apb(1'b1, A_CTRL, 32'h2101);
    press(1'b1, 1'b0);
    waitFreq(fref, 3000);
    @(posedge clk);
    enOn <= 1'b0;
    waitFreq(16'h0, 3000);
    @(posedge clk);
    enOn <= 1'b1;
    repeat (100) @(negedge clk);
    note(3'h0, 32'h0);
    stopNow();
    apb(1'b1, A_ADWELL, 32'h00010014);
    press(1'b1, 1'b0);
    waitFreq(16'h0014, 3000);
    repeat (500) @(negedge clk);
    note(3'h0, 32'h14);
    waitFreq(fref, 3000);
    // Reference drop below dwell point must not dwell
    apb(1'b1, A_DDWELL, 32'h00010014);
    apb(1'b1, A_FREF, 32'h0000000A);
    waitFreq(16'h000A, 900);
    apb(1'b1, A_FREF, {16'h0, fref});
    waitFreq(fref, 900);
    @(posedge clk);
    stopOpen <= 1'b1;
    repeat (2 * TCK + 2) @(posedge clk);
    stopOpen <= 1'b0;
    waitFreq(16'h0014, 3000);
    repeat (500) @(negedge clk);
    note(3'h0, 32'h14);
    // Restart inside the deceleration hold skips the start dwell
    press(1'b1, 1'b0);
    waitFreq(fref, 900);
    stopNow();
    apb(1'b1, A_CTRL, 32'h2011);
    @(posedge clk);
    enOn <= 1'b0;
    press(1'b1, 1'b0);
    waitFreq(fref, 900);
    summarize();
  end
endmodule : rcs_run_sequencer_tb
